// ===== pcm_pkg.sv
package pcm_pkg;

    // register byte offsets
    localparam int              ADDR_W       = 5;
    localparam logic [4:0]      OFS_CMP_A    = 5'h00;
    localparam logic [4:0]      OFS_CTRL     = 5'h04;
    localparam logic [4:0]      OFS_ACT_A    = 5'h08;
    localparam logic [4:0]      OFS_ACT_B    = 5'h0C;

    // field positions
    localparam int              CTRL_LOAD_LSB   = 0;
    localparam int              CTRL_DIRECT_BIT = 4;
    localparam int              CTRL_OCC_BIT    = 8;
    localparam int              ACT_COMPARE_A_VALUE_LSB    = 0;

    // reset values
    localparam logic [15:0]     CMP_A_RST    = 16'h0000;
    localparam logic            DIRECT_RST   = 1'b0;
    localparam logic [1:0]      LOAD_RST     = 2'h0;
    localparam logic [1:0]      ACT_RST      = 2'h0;
    localparam logic            PWM_RST      = 1'b0;

    // bus responses
    localparam logic [1:0]      RESP_OKAY    = 2'h0;
    localparam logic [1:0]      RESP_SLVERR  = 2'h2;

    // response of one output to the compare event
    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_LOW    = 2'h1,
        ACT_HIGH   = 2'h2,
        ACT_TOGGLE = 2'h3
    } pcm_action_type;

    // event that moves shadow into active
    typedef enum logic [1:0] {
        LOAD_ZERO   = 2'h0,
        LOAD_PERIOD = 2'h1,
        LOAD_EITHER = 2'h2,
        LOAD_FREEZE = 2'h3
    } pcm_load_type;

    // one accepted register write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } pcm_wreq_type;

endpackage

// ===== pcm_action_out.sv
`timescale 1ns/1ps
module pcm_action_out
    import pcm_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst,
    input  wire logic           cmpEvent,
    input  wire pcm_action_type actCfg,
    output logic                pwmOut
);

    logic pwmQ;

    // qualify the compare event into the configured pin action
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pwmQ <= PWM_RST;
        end else if (cmpEvent) begin
            case (actCfg)
                ACT_LOW:    pwmQ <= 1'b0;
                ACT_HIGH:   pwmQ <= 1'b1;
                ACT_TOGGLE: pwmQ <= ~pwmQ;
                default:    pwmQ <= pwmQ;  // event ignored
            endcase
        end
    end

    assign pwmOut = pwmQ;

endmodule // pcm_action_out

// ===== pcm_axil_slave.sv
`timescale 1ns/1ps
module pcm_axil_slave
    import pcm_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output pcm_wreq_type           wrReq,
    output logic                   wrPulse,
    input  wire logic              wrHit,
    output logic [ADDR_W-1:0]      rdAddr,
    input  wire logic [31:0]       rdData,
    input  wire logic              rdHit
);

    logic         awready_q;
    logic         wready_q;
    logic         bvalid_q;
    logic [1:0]   bresp_q;
    logic         wrPulse_q;
    pcm_wreq_type wrReq_q;
    logic         arready_q;
    logic         rvalid_q;
    logic [1:0]   rresp_q;
    logic [31:0]  rdata_q;
    logic         fire;

    // both halves held and no answer outstanding
    assign fire = !awready_q && !wready_q && !bvalid_q && !wrPulse_q;

    // write address and data are taken in either order
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            wrReq_q   <= '0;
        end else if (bvalid_q && bready) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
        end else begin
            if (awvalid && awready_q) begin
                wrReq_q.addr <= awaddr;
                awready_q    <= 1'b0;
            end
            if (wvalid && wready_q) begin
                wrReq_q.data <= wdata;
                wrReq_q.strb <= wstrb;
                wready_q     <= 1'b0;
            end
        end
    end

    // one-cycle write strobe, then the response
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPulse_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            wrPulse_q <= fire;
            if (wrPulse_q) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read data is captured on the address handshake
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= rdHit ? RESP_OKAY : RESP_SLVERR;
            rdata_q   <= rdHit ? rdData : 32'h0000_0000;
        end else if (rvalid_q && rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign wrReq   = wrReq_q;
    assign wrPulse = wrPulse_q;
    assign rdAddr  = araddr;

endmodule // pcm_axil_slave

// ===== pcm_compare_a.sv
// Notes on behaviour
// - compare active value with counter every cycle
// - counter equal to value raises event
// - event goes to the action logic
// - event may act on either output
// - actions: ignore, low, high, toggle
// - shadowed mode after reset
// - shadowed mode: accesses reach the shadow
// - direct mode: accesses reach active register
// - one address, mode picks the register
`timescale 1ns/1ps
module pcm_compare_a
    import pcm_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic [15:0]       timebaseCount,
    input  wire logic              ctrZero,
    input  wire logic              ctrPeriod,
    output logic                   cmpEqualA,
    output logic                   cmpEventA,
    output logic                   pwmOutA,
    output logic                   pwmOutB
);

    pcm_wreq_type      wrReq;
    logic              wrPulse;
    logic              wrHit;
    logic [ADDR_W-1:0] rdAddr;
    logic [31:0]       rdData;
    logic              rdHit;

    logic [15:0]       activeQ;
    logic [15:0]       shadowQ;
    logic              occupiedQ;
    logic              directSelQ;
    pcm_load_type      loadSelQ;
    pcm_action_type    actCfgA_q;
    pcm_action_type    actCfgB_q;
    logic              cmpEqualA_q;
    logic              cmpEventA_q;

    logic              wrCmp;
    logic              loadEvent;
    logic              equalNow;
    logic              matchEvt;

    // decode shared by the write and read paths
    function automatic logic regHit(input logic [ADDR_W-1:0] a);
        regHit = (a == OFS_CMP_A) || (a == OFS_CTRL) ||
                 (a == OFS_ACT_A) || (a == OFS_ACT_B);
    endfunction

    // apply the two low byte lanes to a 16-bit value
    function automatic logic [15:0] mergeLow(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
        mergeLow[7:0]  = s[0] ? d[7:0]  : old[7:0];
        mergeLow[15:8] = s[1] ? d[15:8] : old[15:8];
    endfunction

    pcm_axil_slave u_bus (
        .ref_clk (ref_clk),
        .rst     (rst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wrReq   (wrReq),
        .wrPulse (wrPulse),
        .wrHit   (wrHit),
        .rdAddr  (rdAddr),
        .rdData  (rdData),
        .rdHit   (rdHit)
    );

    assign wrHit = regHit(wrReq.addr);
    assign rdHit = regHit(rdAddr);
    assign wrCmp = wrPulse && (wrReq.addr == OFS_CMP_A);

    // load strobe chosen by the load-select field
    always_comb begin
        case (loadSelQ)
            LOAD_ZERO:   loadEvent = ctrZero;
            LOAD_PERIOD: loadEvent = ctrPeriod;
            LOAD_EITHER: loadEvent = ctrZero || ctrPeriod;
            default:     loadEvent = 1'b0;  // frozen: shadow never loads
        endcase
    end

    // mode and load-select; reset leaves the value shadowed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            directSelQ <= DIRECT_RST;
            loadSelQ   <= pcm_load_type'(LOAD_RST);
        end else if (wrPulse && wrReq.addr == OFS_CTRL && wrReq.strb[0]) begin
            directSelQ <= wrReq.data[CTRL_DIRECT_BIT];
            loadSelQ   <= pcm_load_type'(wrReq.data[CTRL_LOAD_LSB +: 2]);
        end
    end

    // per-output responses to the compare event
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            actCfgA_q <= pcm_action_type'(ACT_RST);
            actCfgB_q <= pcm_action_type'(ACT_RST);
        end else if (wrPulse && wrReq.strb[0]) begin
            if (wrReq.addr == OFS_ACT_A) begin
                actCfgA_q <= pcm_action_type'(wrReq.data[ACT_COMPARE_A_VALUE_LSB +: 2]);
            end
            if (wrReq.addr == OFS_ACT_B) begin
                actCfgB_q <= pcm_action_type'(wrReq.data[ACT_COMPARE_A_VALUE_LSB +: 2]);
            end
        end
    end

    // shadow takes software writes only in shadowed mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shadowQ <= CMP_A_RST;
        end else if (wrCmp && !directSelQ) begin
            shadowQ <= mergeLow(shadowQ, wrReq.data, wrReq.strb);
        end
    end

    // active value: direct write, or load from the shadow
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            activeQ <= CMP_A_RST;
        end else if (wrCmp && directSelQ) begin
            activeQ <= mergeLow(activeQ, wrReq.data, wrReq.strb);
        end else if (!directSelQ && loadEvent) begin
            activeQ <= shadowQ;
        end
    end

    // occupied flag; a write in the load cycle keeps it set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            occupiedQ <= 1'b0;
        end else if (wrCmp && !directSelQ) begin
            occupiedQ <= 1'b1;
        end else if (!directSelQ && loadEvent) begin
            occupiedQ <= 1'b0;
        end
    end

    // full-width compare; event fires once per arrival at the value
    assign equalNow = (timebaseCount == activeQ);
    assign matchEvt = equalNow && !cmpEqualA_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmpEqualA_q <= 1'b0;
            cmpEventA_q <= 1'b0;
        end else begin
            cmpEqualA_q <= equalNow;
            cmpEventA_q <= matchEvt;
        end
    end

    assign cmpEqualA = cmpEqualA_q;
    assign cmpEventA = cmpEventA_q;

    // the same event drives both outputs, each with its own setting
    pcm_action_out u_actA (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .cmpEvent (matchEvt),
        .actCfg   (actCfgA_q),
        .pwmOut   (pwmOutA)
    );

    pcm_action_out u_actB (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .cmpEvent (matchEvt),
        .actCfg   (actCfgB_q),
        .pwmOut   (pwmOutB)
    );

    // read mux; the value address follows the mode
    always_comb begin
        rdData = 32'h0000_0000;
        case (rdAddr)
            OFS_CMP_A: rdData[15:0] = directSelQ ? activeQ : shadowQ;
            OFS_CTRL: begin
                rdData[CTRL_LOAD_LSB +: 2] = loadSelQ;
                rdData[CTRL_DIRECT_BIT]    = directSelQ;
                rdData[CTRL_OCC_BIT]       = occupiedQ;
            end
            OFS_ACT_A: rdData[ACT_COMPARE_A_VALUE_LSB +: 2] = actCfgA_q;
            OFS_ACT_B: rdData[ACT_COMPARE_A_VALUE_LSB +: 2] = actCfgB_q;
            default:   rdData = 32'h0000_0000;
        endcase
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_shadowWrite;
        wrCmp && !directSelQ && !loadEvent;
    endsequence

    sequence s_load;
        !directSelQ && loadEvent && !wrCmp;
    endsequence

    sequence s_readCmp;
        arvalid && arready && (araddr == OFS_CMP_A);
    endsequence

    property p_equal_level;
        (timebaseCount == activeQ) |=> cmpEqualA;
    endproperty
    a_equal_level: assert property (p_equal_level) else $error("equal flag missed");

    property p_event_once;
        cmpEventA |-> cmpEqualA && !$past(cmpEqualA);
    endproperty
    a_event_once: assert property (p_event_once) else $error("bad event pulse");

    property p_high_a;
        (matchEvt && actCfgA_q == ACT_HIGH) |=> pwmOutA && cmpEventA;
    endproperty
    a_high_a: assert property (p_high_a) else $error("output A not set");

    property p_low_b;
        (matchEvt && actCfgB_q == ACT_LOW) |=> !pwmOutB;
    endproperty
    a_low_b: assert property (p_low_b) else $error("output B not cleared");

    property p_toggle_a;
        (matchEvt && actCfgA_q == ACT_TOGGLE) |=> pwmOutA != $past(pwmOutA);
    endproperty
    a_toggle_a: assert property (p_toggle_a) else $error("output A not toggled");

    property p_ignore_b;
        (!matchEvt || actCfgB_q == ACT_NONE) |=> $stable(pwmOutB);
    endproperty
    a_ignore_b: assert property (p_ignore_b) else $error("output B moved");

    property p_reset_mode;
        @(posedge ref_clk) disable iff (1'b0) rst |=> !directSelQ && !occupiedQ;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("not shadowed after reset");

    property p_shadow_write;
        s_shadowWrite |=> occupiedQ && $stable(activeQ);
    endproperty
    a_shadow_write: assert property (p_shadow_write) else $error("shadow write leaked");

    property p_load_copy;
        s_load |=> (activeQ == $past(shadowQ)) && !occupiedQ;
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("shadow load wrong");

    property p_direct_write;
        (wrCmp && directSelQ && wrReq.strb[1:0] == 2'b11) |=>
            (activeQ == $past(wrReq.data[15:0])) && $stable(shadowQ);
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("direct write wrong");

    property p_one_address;
        s_readCmp |=> rvalid && rdata[15:0] == ($past(directSelQ) ? $past(activeQ) : $past(shadowQ));
    endproperty
    a_one_address: assert property (p_one_address) else $error("read wrong register");

    property p_occ_set_wins;
        (wrCmp && !directSelQ && loadEvent) |=> occupiedQ;
    endproperty
    a_occ_set_wins: assert property (p_occ_set_wins) else $error("occupied lost");

endmodule // pcm_compare_a

// ===== pcm_tb_timebase.sv
`timescale 1ns/1ps
// time-base stand-in: an up-counter that wraps at PERIOD, can be frozen and preset
module pcm_tb_timebase
    import pcm_pkg::*;
#(
    parameter logic [15:0] PERIOD = 16'h0063
)(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        setEn,
    input  wire logic [15:0] setVal,
    output logic [15:0]      timebaseCount,
    output logic             ctrZero,
    output logic             ctrPeriod
);
    logic [15:0] count_q;

    // preset wins over counting so the bench can park the count on any value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= 16'h0000;
        end else if (setEn) begin
            count_q <= setVal;
        end else if (run) begin
            count_q <= (count_q == PERIOD) ? 16'h0000 : count_q + 16'h0001;
        end
    end

    // strobes follow the count directly, so a parked zero loads on every cycle
    assign timebaseCount = count_q;
    assign ctrZero       = (count_q == 16'h0000);
    assign ctrPeriod     = (count_q == PERIOD);
endmodule // pcm_tb_timebase

// ===== tb_pcm_compare_a.sv
`timescale 1ns/1ps
module tb_pcm_compare_a import pcm_pkg::*;;
    localparam logic [15:0] PERIOD = 16'h0063;
    logic              ref_clk = 1'b0;
    logic              rst     = 1'b1;
    logic [ADDR_W-1:0] awaddr  = '0, araddr = '0;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0]       wdata   = '0;
    logic [3:0]        wstrb   = '0;
    logic              run     = 1'b0, setEn = 1'b0;
    logic [15:0]       setVal  = '0;
    logic              awready, wready, bvalid, arready, rvalid, cmpEqualA, cmpEventA, pwmOutA, pwmOutB;
    logic [1:0]        bresp, rresp, rsp;
    logic [31:0]       rdata, rd;
    logic [15:0]       timebaseCount;
    logic              ctrZero, ctrPeriod, expA, expB;
    int                error_cnt = 0, num_checks = 0, evCnt = 0, base;
    logic [ADDR_W-1:0] ofsList [4] = '{OFS_CMP_A, OFS_CTRL, OFS_ACT_A, OFS_ACT_B};

    always #2.5 ref_clk = ~ref_clk;

    pcm_compare_a dut_u (
        .ref_clk(ref_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .timebaseCount(timebaseCount),
        .ctrZero(ctrZero), .ctrPeriod(ctrPeriod), .cmpEqualA(cmpEqualA), .cmpEventA(cmpEventA),
        .pwmOutA(pwmOutA), .pwmOutB(pwmOutB)
    );

    pcm_tb_timebase #(.PERIOD(PERIOD)) tbase_u (
        .ref_clk(ref_clk), .rst(rst), .run(run), .setEn(setEn), .setVal(setVal),
        .timebaseCount(timebaseCount), .ctrZero(ctrZero), .ctrPeriod(ctrPeriod)
    );

    // count compare events so a held match can be seen to fire only once
    always @(posedge ref_clk) begin
        if (!rst && cmpEventA === 1'b1) begin
            evCnt <= evCnt + 1;
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    // write master: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic awDone = 1'b0;
        logic wDone  = 1'b0;
        @(posedge ref_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge ref_clk);
            if (!awDone && awready === 1'b1) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge ref_clk);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        rd  = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    // park the counter, then give the compare path time to answer
    task automatic set_count(input logic [15:0] v);
        @(posedge ref_clk);
        setEn  <= 1'b1;
        setVal <= v;
        @(posedge ref_clk);
        setEn <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    function automatic logic next_out(input logic cur, input logic [1:0] code);
        case (code)
            2'h1: return 1'b0;
            2'h2: return 1'b1;
            2'h3: return ~cur;
            default: return cur;
        endcase
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            axi_read(ofsList[i]);
            chk32(rd, 32'h0000_0000);
            chk32({30'h0, rsp}, {30'h0, RESP_OKAY});
        end
        axi_read(5'h10);
        chk32({30'h0, rsp}, {30'h0, RESP_SLVERR});
        axi_write(5'h14, 32'h0000_FFFF);
        chk32({30'h0, rsp}, {30'h0, RESP_SLVERR});
        $display("test reset_and_map done");
        // shadowed path: value waits in the shadow until the zero load
        set_count(16'h0300);
        axi_read(OFS_CTRL);
        chk32(rd, 32'h0000_0000);
        axi_write(OFS_CMP_A, 32'h0000_1234);
        axi_read(OFS_CTRL);
        chk32(rd, 32'h0000_0100);
        axi_read(OFS_CMP_A);
        chk32(rd, 32'h0000_1234);
        set_count(16'h1234);
        chk1(cmpEqualA, 1'b0);
        set_count(16'h0000);
        axi_read(OFS_CTRL);
        chk32(rd, 32'h0000_0000);
        base = evCnt;
        set_count(16'h1234);
        chk1(cmpEqualA, 1'b1);
        repeat (5) @(posedge ref_clk);
        chk32(32'(evCnt - base), 32'h0000_0001);
        // write while a parked period strobe loads every cycle: set wins, next cycle loads it
        axi_write(OFS_CTRL, 32'h0000_0001);
        set_count(PERIOD);
        axi_write(OFS_CMP_A, 32'h0000_0200);
        set_count(16'h0200);
        chk1(cmpEqualA, 1'b1);
        $display("test shadow done");
        // every load select against a zero strobe, then a period strobe
        for (int s = 0; s < 4; s++) begin
            axi_write(OFS_CTRL, 32'(s));
            set_count(16'h0300);  // park off both strobes so the write stays pending
            axi_write(OFS_CMP_A, 32'h0000_0100 + 32'(s));
            set_count(16'h0000);
            axi_read(OFS_CTRL);
            chk32(rd, {23'h0, (s == 1 || s == 3), 6'h0, 2'(s)});
            set_count(PERIOD);
            axi_read(OFS_CTRL);
            chk32(rd, {23'h0, (s == 3), 6'h0, 2'(s)});
            set_count(16'h0100 + 16'(s));
            chk1(cmpEqualA, s != 3);
        end
        $display("test load_select done");
        // direct mode reaches the active value at the same address
        axi_write(OFS_CTRL, 32'h0000_0010);
        axi_write(OFS_CMP_A, 32'h0000_0055);
        axi_read(OFS_CMP_A);
        chk32(rd, 32'h0000_0055);
        axi_read(OFS_CTRL);
        chk32(rd, 32'h0000_0110);
        set_count(16'h0055);
        chk1(cmpEqualA, 1'b1);
        for (int i = 0; i < 2; i++) begin
            axi_write(OFS_CMP_A, (i == 0) ? 32'h0000_FFFF : 32'h0000_8001);
            set_count((i == 0) ? 16'h7FFF : 16'h0001);
            chk1(cmpEqualA, 1'b0);
            set_count((i == 0) ? 16'hFFFF : 16'h8001);
            chk1(cmpEqualA, 1'b1);
        end
        $display("test direct done");
        // all four responses on both outputs, A and B walking opposite codes
        axi_write(OFS_CMP_A, 32'h0000_0055);
        expA = 1'b0;
        expB = 1'b0;
        for (int i = 0; i < 4; i++) begin
            axi_write(OFS_ACT_A, 32'(i));
            axi_write(OFS_ACT_B, 32'(3 - i));
            set_count(16'h0054);
            set_count(16'h0055);
            expA = next_out(expA, 2'(i));
            expB = next_out(expB, 2'(3 - i));
            chk1(pwmOutA, expA);
            chk1(pwmOutB, expB);
        end
        $display("test actions done");
        // free-running count crosses the value once per period
        set_count(16'h0000);
        base = evCnt;
        run <= 1'b1;
        repeat (300) @(posedge ref_clk);
        run <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk32(32'(evCnt - base), 32'h0000_0003);
        $display("test running done");
        complete_run();
    end

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        complete_run();
    end
endmodule // tb_pcm_compare_a
